// file: design/sensor_correction_pkg.sv
// Notes on behaviour
// - Region-two gain applies only to region-two part
// - Third-order mode reuses region-two quadratic as cubic
// - Temperature delta scales offset and gain drift
// - Temperature is quadratic polynomial of raw temperature
// - Temperature coefficients are signed sixteen-bit values
// - Corrected temperature is confined to signed sixteen bits
// - Output select pattern 10 enables pulse-density outputs
// - Pulse-density levels clip between programmable limits
// - Capacitance and temperature get separate pulse-density streams
// - Update Mode waits a power-down period between cycles
// - Sleep Mode measures only on host command
// - Address lock uses the configured slave address
// - Active-low open-drain high alarm only sinks current
// - Outside third-order mode, split corrected value at breakpoint into two regions
// - Single-region mode applies gain, quadratic and cubic terms
// - Without address lock, any slave address is accepted
package sensor_correction_pkg;

    // ------------------------------------------------------------
    // Arithmetic format
    // ------------------------------------------------------------
    localparam int                 FRAC_BITS      = 12;
    localparam int                 TEMP_SQ_SHIFT  = 28;
    localparam int                 TEMP_LIN_SHIFT = 14;
    localparam logic signed [47:0] SAT_HI         = 48'sh0000_0000_7FFF;
    localparam logic signed [47:0] SAT_LO         = 48'shFFFF_FFFF_8000;
    localparam logic signed [47:0] UNITY          = 48'sh0000_0000_1000;
    localparam logic signed [15:0] DEN_MIN        = 16'sh0001;

    // ------------------------------------------------------------
    // Output selection and pulse-density format
    // ------------------------------------------------------------
    localparam logic [1:0]  OUT_SEL_PDM = 2'h2;
    localparam int          PDM_W       = 14;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ           = 200;
    localparam int POWER_DOWN_MS     = 25;
    localparam int POWER_DOWN_CYCLES = POWER_DOWN_MS * CLK_MHZ * 1000;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [31:0] COUNT_RST  = 32'h0000_0000;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0]
    {
        ST_IDLE  = 4'h0,
        ST_WAIT  = 4'h1,
        ST_TEMP  = 4'h2,
        ST_DRIFT = 4'h3,
        ST_DIV   = 4'h4,
        ST_SPLIT = 4'h5,
        ST_GAIN  = 4'h6,
        ST_POLY  = 4'h7,
        ST_DONE  = 4'h8,
        ST_PWRDN = 4'h9
    } state_type;

endpackage : sensor_correction_pkg

// file: design/sensor_correction_datapath.sv
`timescale 1ns/10ps
module sensor_correction_datapath
#(
    parameter int POWER_DOWN_CYCLES = sensor_correction_pkg::POWER_DOWN_CYCLES
)
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Mode configuration
    input  wire logic               update_mode,
    input  wire logic               third_order_mode,
    input  wire logic [1:0]         output_select,
    // Host command and front end samples
    input  wire logic               meas_cmd,
    input  wire logic               raw_valid,
    input  wire logic [13:0]        raw_cap,
    input  wire logic [13:0]        raw_temp,
    // Capacitance coefficients
    input  wire logic signed [15:0] cap_offset,
    input  wire logic signed [15:0] region_one_gain,
    input  wire logic signed [15:0] region_one_quadratic,
    input  wire logic signed [15:0] region_two_gain,
    input  wire logic signed [15:0] region_two_quadratic,
    input  wire logic signed [15:0] region_break,
    input  wire logic signed [15:0] offset_drift,
    input  wire logic signed [15:0] offset_drift_quadratic,
    input  wire logic signed [15:0] gain_drift,
    input  wire logic signed [15:0] gain_drift_quadratic,
    input  wire logic [13:0]        temp_reference,
    // Temperature coefficients
    input  wire logic signed [15:0] temp_gain_coef,
    input  wire logic signed [15:0] temp_offset_coef,
    input  wire logic signed [15:0] temp_quadratic_coef,
    // Pulse-density clipping
    input  wire logic [13:0]        pulse_density_lower_limit,
    input  wire logic [13:0]        pulse_density_upper_limit,
    // High alarm
    input  wire logic               alarm_high_cond,
    input  wire logic               alarm_high_active_low,
    input  wire logic               alarm_high_open_drain,
    // Slave address check
    input  wire logic               addr_lock,
    input  wire logic [6:0]         config_address,
    input  wire logic [6:0]         bus_address,
    // Results
    output logic                    meas_start_q,
    output logic                    result_valid_q,
    output logic signed [15:0]      cap_out_q,
    output logic signed [15:0]      temp_out_q,
    output logic                    pdm_cap_q,
    output logic                    pdm_temp_q,
    output logic                    alarm_high_q,
    output logic                    alarm_high_oe_q,
    output logic                    addr_match_q
);

    if (POWER_DOWN_CYCLES < 1)
        $error("POWER_DOWN_CYCLES must be at least one");

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic signed [15:0] sat16(
        input logic signed [47:0] v);
        if (v > sensor_correction_pkg::SAT_HI)
            return 16'sh7FFF;
        else if (v < sensor_correction_pkg::SAT_LO)
            return 16'sh8000;
        else
            return v[15:0];
    endfunction : sat16

    function automatic logic signed [15:0] mulq(
        input logic signed [15:0] a,
        input logic signed [15:0] b);
        logic signed [47:0] p;
        p = 48'(a) * 48'(b);
        return sat16(p >>> sensor_correction_pkg::FRAC_BITS);
    endfunction : mulq

    function automatic logic [13:0] clip_level(
        input logic signed [15:0] v,
        input logic [13:0]        lo,
        input logic [13:0]        hi);
        logic [15:0] u;
        u = (v < 16'sh0000) ? 16'h0000 : 16'(v);
        if (u < {2'b00, lo})
            return lo;
        else if (u > {2'b00, hi})
            return hi;
        else
            return u[13:0];
    endfunction : clip_level

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    sensor_correction_pkg::state_type state_q;
    logic [31:0]                      pd_cnt_q;
    logic                             start_w;

    // Sleep Mode starts only on a host command; Update Mode runs alone
    assign start_w = update_mode || meas_cmd;

    always_ff @(posedge clk)
    begin
        if (rst)
            state_q <= sensor_correction_pkg::ST_IDLE;
        else
        begin
            case (state_q)
                sensor_correction_pkg::ST_IDLE:
                    if (start_w)
                        state_q <= sensor_correction_pkg::ST_WAIT;
                sensor_correction_pkg::ST_WAIT:
                    if (raw_valid)
                        state_q <= sensor_correction_pkg::ST_TEMP;
                sensor_correction_pkg::ST_TEMP:
                    state_q <= sensor_correction_pkg::ST_DRIFT;
                sensor_correction_pkg::ST_DRIFT:
                    state_q <= sensor_correction_pkg::ST_DIV;
                sensor_correction_pkg::ST_DIV:
                    state_q <= sensor_correction_pkg::ST_SPLIT;
                sensor_correction_pkg::ST_SPLIT:
                    state_q <= sensor_correction_pkg::ST_GAIN;
                sensor_correction_pkg::ST_GAIN:
                    state_q <= sensor_correction_pkg::ST_POLY;
                sensor_correction_pkg::ST_POLY:
                    state_q <= sensor_correction_pkg::ST_DONE;
                sensor_correction_pkg::ST_DONE:
                    state_q <= update_mode ? sensor_correction_pkg::ST_PWRDN
                                           : sensor_correction_pkg::ST_IDLE;
                sensor_correction_pkg::ST_PWRDN:
                    if (!update_mode || pd_cnt_q == 32'h0000_0000)
                        state_q <= sensor_correction_pkg::ST_IDLE;
                default:
                    state_q <= sensor_correction_pkg::ST_IDLE;
            endcase
        end
    end

    // Power-down period between Update Mode cycles
    always_ff @(posedge clk)
    begin
        if (rst)
            pd_cnt_q <= sensor_correction_pkg::COUNT_RST;
        else if (state_q == sensor_correction_pkg::ST_DONE)
            pd_cnt_q <= 32'(POWER_DOWN_CYCLES - 1);
        else if (pd_cnt_q != 32'h0000_0000)
            pd_cnt_q <= pd_cnt_q - 32'h0000_0001;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meas_start_q   <= 1'b0;
            result_valid_q <= 1'b0;
        end
        else
        begin
            meas_start_q   <= (state_q == sensor_correction_pkg::ST_IDLE)
                              && start_w;
            result_valid_q <= (state_q == sensor_correction_pkg::ST_POLY);
        end
    end

    // ------------------------------------------------------------
    // Temperature correction
    // ------------------------------------------------------------
    logic [13:0]        raw_cap_q;
    logic signed [15:0] dtemp_q;
    logic signed [47:0] rt_w;
    logic signed [47:0] temp_sum_w;

    // Raw temperature is taken as unsigned 0..16383
    assign rt_w = 48'({34'h0, raw_temp});
    assign temp_sum_w =
        ((48'(temp_quadratic_coef) * rt_w * rt_w)
            >>> sensor_correction_pkg::TEMP_SQ_SHIFT)
        + ((48'(temp_gain_coef) * rt_w)
            >>> sensor_correction_pkg::TEMP_LIN_SHIFT)
        + 48'(temp_offset_coef);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            raw_cap_q  <= 14'h0000;
            dtemp_q    <= sensor_correction_pkg::RESULT_RST;
            temp_out_q <= sensor_correction_pkg::RESULT_RST;
        end
        else if (state_q == sensor_correction_pkg::ST_WAIT && raw_valid)
        begin
            raw_cap_q  <= raw_cap;
            dtemp_q    <= signed'({2'b00, raw_temp})
                          - signed'({2'b00, temp_reference});
            temp_out_q <= sat16(temp_sum_w);
        end
    end

    // ------------------------------------------------------------
    // Capacitance correction
    // ------------------------------------------------------------
    logic signed [15:0] num_q;
    logic signed [15:0] den_q;
    logic signed [15:0] rawtc_q;
    logic signed [15:0] r1_q;
    logic signed [15:0] r2_q;
    logic signed [15:0] g1r1_q;
    logic signed [15:0] g2r2_q;
    logic signed [15:0] off_drift_w;
    logic signed [15:0] gain_drift_w;
    logic signed [15:0] den_w;
    logic signed [47:0] quot_w;
    logic signed [15:0] sq1_w;
    logic signed [15:0] sq2_w;
    logic signed [15:0] cube_w;
    logic signed [47:0] poly_w;

    always_comb
    begin
        off_drift_w  = mulq(dtemp_q, sat16(48'(offset_drift)
                       + 48'(mulq(dtemp_q, offset_drift_quadratic))));
        gain_drift_w = mulq(dtemp_q, sat16(48'(gain_drift)
                       + 48'(mulq(dtemp_q, gain_drift_quadratic))));
        den_w        = sat16(sensor_correction_pkg::UNITY
                       + 48'(gain_drift_w));
        // Denominator is held positive; the calibration limits keep
        // real coefficient sets far from this clamp.
        if (den_w < sensor_correction_pkg::DEN_MIN)
            den_w = sensor_correction_pkg::DEN_MIN;
        quot_w = (48'(num_q) <<< sensor_correction_pkg::FRAC_BITS)
                 / 48'(den_q);
        sq1_w  = mulq(g1r1_q, g1r1_q);
        cube_w = mulq(sq1_w, g1r1_q);
        sq2_w  = mulq(g2r2_q, g2r2_q);
        if (third_order_mode)
            poly_w = 48'(mulq(region_two_quadratic, cube_w))
                     + 48'(mulq(region_one_quadratic, sq1_w))
                     + 48'(g1r1_q);
        else
            poly_w = 48'(mulq(region_one_quadratic, sq1_w))
                     + 48'(g1r1_q)
                     + 48'(mulq(region_two_quadratic, sq2_w))
                     + 48'(g2r2_q);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            num_q <= sensor_correction_pkg::RESULT_RST;
            den_q <= 16'sh0001;
        end
        else if (state_q == sensor_correction_pkg::ST_DRIFT)
        begin
            num_q <= sat16(48'({34'h0, raw_cap_q}) + 48'(cap_offset)
                           + 48'(off_drift_w));
            den_q <= den_w;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            rawtc_q <= sensor_correction_pkg::RESULT_RST;
        else if (state_q == sensor_correction_pkg::ST_DIV)
            rawtc_q <= sat16(quot_w);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            r1_q <= sensor_correction_pkg::RESULT_RST;
            r2_q <= sensor_correction_pkg::RESULT_RST;
        end
        else if (state_q == sensor_correction_pkg::ST_SPLIT)
        begin
            if (third_order_mode)
            begin
                r1_q <= rawtc_q;
                r2_q <= 16'sh0000;
            end
            else
            begin
                r1_q <= (rawtc_q < region_break) ? rawtc_q
                                                 : region_break;
                r2_q <= (rawtc_q > region_break)
                        ? sat16(48'(rawtc_q) - 48'(region_break))
                        : 16'sh0000;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            g1r1_q <= sensor_correction_pkg::RESULT_RST;
            g2r2_q <= sensor_correction_pkg::RESULT_RST;
        end
        else if (state_q == sensor_correction_pkg::ST_GAIN)
        begin
            g1r1_q <= mulq(region_one_gain, r1_q);
            g2r2_q <= third_order_mode ? 16'sh0000
                                       : mulq(region_two_gain, r2_q);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            cap_out_q <= sensor_correction_pkg::RESULT_RST;
        else if (state_q == sensor_correction_pkg::ST_POLY)
            cap_out_q <= sat16(poly_w);
    end

    // ------------------------------------------------------------
    // Pulse-density outputs
    // ------------------------------------------------------------
    logic        pdm_on_w;
    logic [13:0] cap_level_w;
    logic [13:0] temp_level_w;
    logic [13:0] cap_acc_q;
    logic [13:0] temp_acc_q;
    logic [14:0] cap_sum_w;
    logic [14:0] temp_sum_acc_w;

    assign pdm_on_w = (output_select == sensor_correction_pkg::OUT_SEL_PDM);
    assign cap_level_w    = clip_level(cap_out_q, pulse_density_lower_limit,
                                       pulse_density_upper_limit);
    assign temp_level_w   = clip_level(temp_out_q, pulse_density_lower_limit,
                                       pulse_density_upper_limit);
    assign cap_sum_w      = {1'b0, cap_acc_q} + {1'b0, cap_level_w};
    assign temp_sum_acc_w = {1'b0, temp_acc_q} + {1'b0, temp_level_w};

    // First-order modulators, one per quantity
    always_ff @(posedge clk)
    begin
        if (rst || !pdm_on_w)
        begin
            cap_acc_q  <= 14'h0000;
            temp_acc_q <= 14'h0000;
            pdm_cap_q  <= 1'b0;
            pdm_temp_q <= 1'b0;
        end
        else
        begin
            cap_acc_q  <= cap_sum_w[13:0];
            temp_acc_q <= temp_sum_acc_w[13:0];
            pdm_cap_q  <= cap_sum_w[14];
            pdm_temp_q <= temp_sum_acc_w[14];
        end
    end

    // ------------------------------------------------------------
    // High alarm pin and address check
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            alarm_high_q    <= 1'b0;
            alarm_high_oe_q <= 1'b0;
        end
        else if (alarm_high_open_drain)
        begin
            // Open drain can only pull low, so drive when low is wanted
            alarm_high_q    <= 1'b0;
            alarm_high_oe_q <= alarm_high_cond ~^ alarm_high_active_low;
        end
        else
        begin
            alarm_high_q    <= alarm_high_cond ^ alarm_high_active_low;
            alarm_high_oe_q <= 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            addr_match_q <= 1'b0;
        else
            addr_match_q <= !addr_lock
                            || (bus_address == config_address);
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_temp_first;
        state_q == sensor_correction_pkg::ST_TEMP
        |=> state_q == sensor_correction_pkg::ST_DRIFT ##5
            state_q == sensor_correction_pkg::ST_DONE;
    endproperty
    a_temp_first: assert property (p_temp_first)
        else $error("temperature step not ahead of capacitance");

    property p_sleep_no_start;
        !update_mode && !meas_cmd |=> !meas_start_q;
    endproperty
    a_sleep_no_start: assert property (p_sleep_no_start)
        else $error("measurement started without command");

    property p_pd_load;
        state_q == sensor_correction_pkg::ST_DONE && update_mode
        |=> state_q == sensor_correction_pkg::ST_PWRDN
            && pd_cnt_q == 32'(POWER_DOWN_CYCLES - 1);
    endproperty
    a_pd_load: assert property (p_pd_load)
        else $error("power-down period not loaded");

    property p_single_no_g2;
        state_q == sensor_correction_pkg::ST_GAIN && third_order_mode
        |=> g2r2_q == 16'sh0000;
    endproperty
    a_single_no_g2: assert property (p_single_no_g2)
        else $error("region-two gain used in single region");

    property p_split;
        state_q == sensor_correction_pkg::ST_SPLIT && !third_order_mode
        |=> r1_q <= region_break && r2_q >= 16'sh0000
            && (r2_q == 16'sh0000 || r1_q == region_break);
    endproperty
    a_split: assert property (p_split)
        else $error("region split inconsistent");

    property p_pdm_off;
        !pdm_on_w |=> !pdm_cap_q && !pdm_temp_q;
    endproperty
    a_pdm_off: assert property (p_pdm_off)
        else $error("pulse-density output active while deselected");

    property p_pdm_clip;
        pulse_density_lower_limit <= pulse_density_upper_limit
        |-> cap_level_w >= pulse_density_lower_limit
            && cap_level_w <= pulse_density_upper_limit;
    endproperty
    a_pdm_clip: assert property (p_pdm_clip)
        else $error("pulse-density level outside clip limits");

    property p_od_sink;
        alarm_high_open_drain && alarm_high_active_low && alarm_high_cond
        |=> alarm_high_oe_q && !alarm_high_q;
    endproperty
    a_od_sink: assert property (p_od_sink)
        else $error("open-drain alarm not sinking");

    property p_addr_lock;
        addr_lock && bus_address != config_address |=> !addr_match_q;
    endproperty
    a_addr_lock: assert property (p_addr_lock)
        else $error("foreign address accepted under lock");

    property p_addr_any;
        !addr_lock |=> addr_match_q;
    endproperty
    a_addr_any: assert property (p_addr_any)
        else $error("address refused without lock");

    c_sleep_cycle: cover property (!update_mode && meas_cmd ##[1:20]
                                   result_valid_q);
    c_update_cycle: cover property (update_mode && result_valid_q);
    c_third_order: cover property (third_order_mode && result_valid_q);
    c_pdm_pulse: cover property (pdm_on_w && pdm_cap_q);

endmodule : sensor_correction_datapath

// file: test/front_end_model.sv
`timescale 1ns/10ps
module front_end_model
(
    // Clock and request
    input  wire logic        clk,
    input  wire logic        meas_start,
    input  wire logic [3:0]  delay,
    // Sample values and handshake
    input  wire logic [13:0] cap_val,
    input  wire logic [13:0] temp_val,
    output logic             raw_valid,
    output logic [13:0]      raw_cap,
    output logic [13:0]      raw_temp
);
    // Lines show the inverse outside the valid cycle so a stale sample
    // can never pass for a fresh one
    assign raw_cap  = raw_valid ? cap_val : ~cap_val;
    assign raw_temp = raw_valid ? temp_val : ~temp_val;
    initial raw_valid = 1'b0;
    always @(negedge clk)
    begin
        if (meas_start === 1'b1)
        begin
            repeat (delay) @(negedge clk);
            raw_valid = 1'b1;
            @(negedge clk);
            raw_valid = 1'b0;
        end
    end
endmodule : front_end_model

// file: test/sensor_correction_datapath_bench.sv
`timescale 1ns/10ps
module sensor_correction_datapath_bench;
    logic               clk, rst, update_mode, third_order_mode, meas_cmd;
    logic               alarm_high_cond, alarm_high_active_low, raw_valid;
    logic               alarm_high_open_drain, addr_lock;
    logic [1:0]         output_select;
    logic [3:0]         delay;
    logic [6:0]         config_address, bus_address;
    logic [13:0]        raw_cap, raw_temp, temp_reference, cap_val, temp_val;
    logic [13:0]        pulse_density_lower_limit, pulse_density_upper_limit;
    logic signed [15:0] cap_offset, region_one_gain, region_one_quadratic;
    logic signed [15:0] region_two_gain, region_two_quadratic, region_break;
    logic signed [15:0] offset_drift, offset_drift_quadratic, gain_drift;
    logic signed [15:0] gain_drift_quadratic, temp_gain_coef, cap_out_q;
    logic signed [15:0] temp_offset_coef, temp_quadratic_coef, temp_out_q;
    logic               meas_start_q, result_valid_q, pdm_cap_q, pdm_temp_q;
    logic               alarm_high_q, alarm_high_oe_q, addr_match_q;
    int                 num_errors, total_checks;

    sensor_correction_datapath #(.POWER_DOWN_CYCLES(8))
        u_sensor_correction_datapath
    (.clk, .rst, .update_mode, .third_order_mode, .output_select, .meas_cmd,
     .raw_valid, .raw_cap, .raw_temp, .cap_offset, .region_one_gain,
     .region_one_quadratic, .region_two_gain, .region_two_quadratic,
     .region_break, .offset_drift, .offset_drift_quadratic, .gain_drift,
     .gain_drift_quadratic, .temp_reference, .temp_gain_coef,
     .temp_offset_coef, .temp_quadratic_coef, .pulse_density_lower_limit,
     .pulse_density_upper_limit, .alarm_high_cond, .alarm_high_active_low,
     .alarm_high_open_drain, .addr_lock, .config_address, .bus_address,
     .meas_start_q, .result_valid_q, .cap_out_q, .temp_out_q, .pdm_cap_q,
     .pdm_temp_q, .alarm_high_q, .alarm_high_oe_q, .addr_match_q);

    front_end_model u_front_end_model
    (.clk, .meas_start(meas_start_q), .delay, .cap_val, .temp_val,
     .raw_valid, .raw_cap, .raw_temp);

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task chk(input string what, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    // Sleep Mode measurement; r is the stored reference temperature
    task measure(input logic [13:0] c, t, r);
        int n;
        cap_val = c;
        temp_val = t;
        temp_reference = r;
        meas_cmd = 1'b1;
        @(negedge clk);
        meas_cmd = 1'b0;
        n = 0;
        while (result_valid_q !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        chk("result valid", 16'h0001, {15'h0, result_valid_q});
        @(negedge clk);
    endtask : measure

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_regions;
        third_order_mode = 1'b0;
        measure(14'h05DC, 14'h03E8, 14'h03E8);
        chk("temp", 16'h0295, temp_out_q);
        chk("cap two region", 16'h07D0, cap_out_q);
        measure(14'h05DC, 14'h1F40, 14'h0000);
        chk("cap drift", 16'h07E4, cap_out_q);
        {third_order_mode, region_two_quadratic} = {1'b1, 16'sh1000};
        delay = 4'h6;
        measure(14'h05DC, 14'h03E8, 14'h03E8);
        chk("cap one region", 16'h06A5, cap_out_q);
        {third_order_mode, region_two_quadratic} = '0;
        $display("test regions done");
    endtask : t_regions

    task t_temp_sat;
        {temp_gain_coef, temp_offset_coef} = {16'sh7FFF, 16'sh7FFF};
        measure(14'h05DC, 14'h3FFF, 14'h3FFF);
        chk("temp high", 16'h7FFF, temp_out_q);
        {temp_gain_coef, temp_offset_coef} = {16'sh8000, 16'sh8000};
        measure(14'h05DC, 14'h3FFF, 14'h3FFF);
        chk("temp low", 16'h8000, temp_out_q);
        {temp_gain_coef, temp_offset_coef} = {16'sh2000, 16'sh0064};
        $display("test temperature saturation done");
    endtask : t_temp_sat

    task t_pdm;
        int nc, nt;
        measure(14'h05DC, 14'h03E8, 14'h03E8);
        {nc, nt} = '0;
        repeat (64) @(negedge clk) nc += pdm_cap_q | pdm_temp_q;
        chk("pdm off", 16'h0000, 16'(nc));
        {output_select, update_mode} = {2'h2, 1'b1};
        repeat (4) @(negedge clk);
        {nc, nt} = '0;
        repeat (16384) @(negedge clk)
        begin
            nc += pdm_cap_q;
            nt += pdm_temp_q;
        end
        chk("pdm cap ones", 16'h07D0, 16'(nc));
        chk("pdm temp ones", 16'h0666, 16'(nt));
        {output_select, update_mode} = '0;
        $display("test pulse density done");
    endtask : t_pdm

    task t_pins;
        logic lvl;
        for (int i = 0; i < 8; i++)
        begin
            {alarm_high_active_low, alarm_high_open_drain} = i[2:1];
            alarm_high_cond = i[0];
            addr_lock = (i != 2);
            bus_address = (i == 0) ? 7'h28 : 7'h29;
            repeat (2) @(negedge clk);
            lvl = alarm_high_cond ^ alarm_high_active_low;
            chk("alarm", {14'h0, alarm_high_open_drain ? ~lvl : 1'b1,
                alarm_high_open_drain ? 1'b0 : lvl},
                {14'h0, alarm_high_oe_q, alarm_high_q});
            chk("addr", {15'h0, i == 0 || i == 2},
                {15'h0, addr_match_q});
        end
        $display("test pins done");
    endtask : t_pins

    task t_modes;
        int n;
        n = 0;
        repeat (30) @(negedge clk) n += meas_start_q;
        chk("sleep start", 16'h0000, 16'(n));
        update_mode = 1'b1;
        n = 0;
        while (result_valid_q !== 1'b1 && n < 200) @(negedge clk) n++;
        n = 0;
        do @(negedge clk) n++; while (meas_start_q !== 1'b1 && n < 200);
        chk("power down", 16'h0001, {15'h0, n >= 9 && n <= 12});
        update_mode = 1'b0;
        repeat (40) @(negedge clk);
        $display("test modes done");
    endtask : t_modes

    initial
    begin
        {num_errors, total_checks, rst} = {32'h0, 32'h0, 1'b1};
        {update_mode, third_order_mode, meas_cmd, alarm_high_cond} = '0;
        {alarm_high_active_low, alarm_high_open_drain, addr_lock} = '0;
        {output_select, delay, cap_val, temp_val, temp_reference} = '0;
        {cap_offset, region_one_quadratic, region_two_quadratic} = '0;
        {offset_drift_quadratic, gain_drift_quadratic} = '0;
        {temp_quadratic_coef, region_one_gain} = {16'sh4000, 16'sh1000};
        {region_two_gain, region_break} = {16'sh2000, 16'sh03E8};
        {offset_drift, gain_drift} = {16'sh0018, 16'sh0031};
        {temp_gain_coef, temp_offset_coef} = {16'sh2000, 16'sh0064};
        pulse_density_lower_limit = 14'h0666;
        pulse_density_upper_limit = 14'h3999;
        {config_address, bus_address} = {7'h28, 7'h28};
        repeat (12) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_regions();
        t_temp_sat();
        t_pdm();
        t_pins();
        t_modes();
        give_verdict();
    end

    // Whole run needs about 16700 cycles
    initial
    begin
        repeat (60000) @(posedge clk);
        num_errors++;
        give_verdict();
    end
endmodule : sensor_correction_datapath_bench
